/* File: verilog/lmc_map.svh */
// register offsets, reset values, field positions and timing constants of the control bank
`ifndef LMC_MAP_SVH
`define LMC_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LMC_ADDR_FRAME_TIMING    8'h03
`define LMC_ADDR_DISPLAY_OPT     8'h04
`define LMC_ADDR_SEG_CURRENT     8'h05
`define LMC_ADDR_DEVICE_CFG      8'h06
`define LMC_ADDR_IRQ_MASK        8'h07
`define LMC_ADDR_IRQ_FRAME       8'h08
`define LMC_ADDR_POWER_TEST      8'h09
`define LMC_ADDR_BUS_WDOG        8'h0A
`define LMC_ADDR_CLOCK_SRC       8'h0B
`define LMC_ADDR_IRQ_STATUS      8'h0E
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LMC_RST_FRAME_TIMING     8'h00
`define LMC_RST_DISPLAY_OPT      8'h20
`define LMC_RST_SEG_CURRENT      8'h00
`define LMC_RST_DEVICE_CFG       8'h00
`define LMC_RST_IRQ_MASK         8'h20
`define LMC_RST_IRQ_FRAME        6'h3F
`define LMC_RST_POWER_TEST       8'h02
`define LMC_RST_BUS_WDOG         8'hFF
`define LMC_RST_CLOCK_SRC        8'h00
`define LMC_RST_IRQ_STATUS       8'h20
`define LMC_CLR_IRQ_STATUS       8'h00
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LMC_FT_FADE              7
`define LMC_FT_DIR_LEFT          6
`define LMC_FT_BLOCK             5
`define LMC_FT_SCROLL            4
`define LMC_DO_BLINK_LONG        4
`define LMC_CFG_LOWVDD_CLR       7
`define LMC_CFG_LOWVDD_PIN       6
`define LMC_CFG_OPEN_DIS         5
`define LMC_CFG_COMMON_ADDR      3
`define LMC_PT_TEST_ALL          4
`define LMC_PT_AUTO_TEST         3
`define LMC_PT_MANUAL_TEST       2
`define LMC_PT_INIT              1
`define LMC_PT_SHDN              0
`define LMC_WD_ENABLE            0
`define LMC_CK_SYNC_OUT          1
`define LMC_CK_SYNC_IN           0
`define LMC_IS_FRAME             7
`define LMC_IS_WDOG              6
`define LMC_IS_OVERTEMP          4
`define LMC_IS_LOWVDD            3
`define LMC_IS_OPEN              2
`define LMC_IS_SHORT             1
`define LMC_IS_MOVIE             0
`define LMC_LOOPS_ENDLESS        3'h7
`define LMC_SCAN_MAX             4'hB
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LMC_CLK_PERIOD_NS        10
`define LMC_FRAME_STEP_NS        32500000
`define LMC_BLINK_SHORT_HALF_NS  750000000
`define LMC_BLINK_LONG_HALF_NS   1500000000
`define LMC_REFRESH_HZ           430
`define LMC_SEG_COUNT            12
`define LMC_WDOG_UNIT_NS         256000
`define LMC_SYNC_1M_NS           1000
`define LMC_SYNC_500K_NS         2000
`define LMC_SYNC_125K_NS         8000
`define LMC_SYNC_32K_NS          31250
`endif

/* File: verilog/lmc_pkg.sv */
// state types of the led matrix control register bank
package lmc_pkg;
  // core clock domain state
  typedef struct packed {
    logic [7:0]  frame_timing;
    logic [7:0]  display_opt;
    logic [7:0]  seg_current;
    logic [7:0]  device_cfg;
    logic [7:0]  irq_mask;
    logic [5:0]  irq_frame;
    logic [7:0]  power_test;
    logic [7:0]  bus_wdog;
    logic [7:0]  clock_src;
    logic [7:0]  irq_status;
    logic        mem_locked;
    logic        req_s1;
    logic        req_s2;
    logic        ack;
    logic [7:0]  rdata;
    logic [31:0] frame_cnt;
    logic        frame_tick;
    logic [31:0] blink_cnt;
    logic        blink_phase;
    logic [31:0] seg_cnt;
    logic [3:0]  seg;
    logic        seg_strobe;
    logic [15:0] sync_cnt;
    logic        sync_lvl;
    logic        sda_s1;
    logic        sda_s2;
    logic [31:0] wd_cnt;
    logic        i2c_reset;
    logic        test_start;
  } lmc_core_t;

  // link clock domain state
  typedef struct packed {
    logic        busy;
    logic        req;
    logic        ack_s1;
    logic        ack_s2;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;
  } lmc_link_t;
endpackage : lmc_pkg

/* File: verilog/lmc_ctrl_regs.sv */
// control register bank of the led matrix driver with its timers and event flags
`timescale 1ns/1ps
`default_nettype none
`include "lmc_map.svh"
module lmc_ctrl_regs
  import lmc_pkg::*;
#(
  parameter logic [31:0] FRAME_STEP_CYC  = `LMC_FRAME_STEP_NS / `LMC_CLK_PERIOD_NS,
  parameter logic [31:0] BLINK_SHORT_CYC = `LMC_BLINK_SHORT_HALF_NS / `LMC_CLK_PERIOD_NS,
  parameter logic [31:0] BLINK_LONG_CYC  = `LMC_BLINK_LONG_HALF_NS / `LMC_CLK_PERIOD_NS,
  parameter logic [31:0] SEG_CYC         =
    1000000000 / (`LMC_REFRESH_HZ * `LMC_SEG_COUNT) / `LMC_CLK_PERIOD_NS,
  parameter logic [31:0] WDOG_UNIT_CYC   = `LMC_WDOG_UNIT_NS / `LMC_CLK_PERIOD_NS
)(
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       link_clk_i,
  input  wire logic       link_wr_i,
  input  wire logic       link_rd_i,
  input  wire logic [7:0] link_addr_i,
  input  wire logic [7:0] link_wdata_i,
  output logic      [7:0] link_rdata_o,
  output logic            link_busy_o,
  input  wire logic       sda_i,
  input  wire logic       movie_active_i,
  input  wire logic       display_start_i,
  input  wire logic       display_end_i,
  input  wire logic       frame_shown_i,
  input  wire logic [5:0] frame_idx_i,
  input  wire logic       final_pass_i,
  input  wire logic       movie_done_i,
  input  wire logic       overtemp_i,
  input  wire logic       low_vdd_i,
  input  wire logic       open_err_i,
  input  wire logic       short_err_i,
  input  wire logic       data_write_i,
  output logic            frame_tick_o,
  output logic            frame_once_o,
  output logic            fade_en_o,
  output logic            scroll_left_o,
  output logic            scroll_block_o,
  output logic            scroll_en_o,
  output logic      [2:0] loops_o,
  output logic            loop_endless_o,
  output logic            blink_phase_o,
  output logic      [3:0] seg_sel_o,
  output logic            seg_strobe_o,
  output logic      [3:0] test_seg_limit_o,
  output logic      [7:0] segment_current_o,
  output logic            led_open_disable_o,
  output logic            common_addr_en_o,
  output logic      [2:0] mem_conf_o,
  output logic            mem_locked_o,
  output logic            test_start_o,
  output logic            test_all_o,
  output logic            outputs_off_o,
  output logic            fsm_reset_o,
  output logic            i2c_reset_o,
  output logic            osc_en_o,
  output logic            ext_clk_sel_o,
  output logic            sync_o,
  output logic            sync_oe_o,
  output logic            irq_o,
  output logic            irq_oe_o
);
  // ---------------------------------------------------------------
  // sync output half periods
  // ---------------------------------------------------------------
  localparam logic [15:0] SYNC_HALF_1M   = 16'(`LMC_SYNC_1M_NS / 2 / `LMC_CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_HALF_500K = 16'(`LMC_SYNC_500K_NS / 2 / `LMC_CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_HALF_125K = 16'(`LMC_SYNC_125K_NS / 2 / `LMC_CLK_PERIOD_NS);
  localparam logic [15:0] SYNC_HALF_32K  = 16'(`LMC_SYNC_32K_NS / 2 / `LMC_CLK_PERIOD_NS);

  lmc_core_t c;
  lmc_core_t next_c;
  lmc_link_t l;
  lmc_link_t next_l;

  logic        pending;
  logic        core_wr;
  logic        core_rd;
  logic        running;
  logic [3:0]  scan_lim;
  logic [31:0] frame_lim;
  logic [31:0] blink_lim;
  logic [31:0] wd_lim;
  logic [15:0] sync_half;
  logic        irq_event;

  // ---------------------------------------------------------------
  // link domain: request capture and answer return
  // ---------------------------------------------------------------
  // a request toggles req; the core answers by copying it into ack
  always_comb
  begin
    next_l        = l;
    next_l.ack_s1 = c.ack;
    next_l.ack_s2 = l.ack_s1;
    if (l.busy && (l.ack_s2 == l.req))
    begin
      next_l.busy  = 1'b0;
      next_l.rdata = c.rdata;  // core holds rdata until the next request
    end
    else if (!l.busy && (link_wr_i || link_rd_i))
    begin
      next_l.busy  = 1'b1;
      next_l.req   = ~l.req;
      next_l.addr  = link_addr_i;
      next_l.wdata = link_wdata_i;
      next_l.we    = link_wr_i;
    end
  end

  // link domain registers
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      l <= '0;
    else
      l <= next_l;
  end

  assign link_rdata_o = l.rdata;
  assign link_busy_o  = l.busy;

  // ---------------------------------------------------------------
  // core domain decode helpers
  // ---------------------------------------------------------------
  // addr, wdata and we are stable in the link domain while busy
  assign pending   = (c.req_s2 != c.ack);
  assign core_wr   = pending && l.we;
  assign core_rd   = pending && !l.we;
  assign running   = c.power_test[`LMC_PT_INIT] && !c.power_test[`LMC_PT_SHDN];
  assign scan_lim  = (c.display_opt[3:0] > `LMC_SCAN_MAX) ? `LMC_SCAN_MAX : c.display_opt[3:0];
  assign frame_lim = FRAME_STEP_CYC * {28'h0, c.frame_timing[3:0]};
  assign blink_lim = c.display_opt[`LMC_DO_BLINK_LONG] ? BLINK_LONG_CYC : BLINK_SHORT_CYC;
  assign wd_lim    = WDOG_UNIT_CYC * {24'h0, 1'b0, c.bus_wdog[7:1]} + WDOG_UNIT_CYC;

  // sync output divider select
  always_comb
  begin
    unique case (c.clock_src[3:2])
      2'h0: sync_half = SYNC_HALF_1M;
      2'h1: sync_half = SYNC_HALF_500K;
      2'h2: sync_half = SYNC_HALF_125K;
      2'h3: sync_half = SYNC_HALF_32K;
    endcase
  end

  // ---------------------------------------------------------------
  // core domain next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_c            = c;
    next_c.req_s1     = l.req;
    next_c.req_s2     = c.req_s1;
    next_c.sda_s1     = sda_i;
    next_c.sda_s2     = c.sda_s1;
    next_c.frame_tick = 1'b0;
    next_c.seg_strobe = 1'b0;
    next_c.i2c_reset  = 1'b0;
    next_c.test_start = 1'b0;

    // register read and write
    if (pending)
    begin
      next_c.ack = c.req_s2;
      if (l.we)
      begin
        unique case (l.addr)
          `LMC_ADDR_FRAME_TIMING: next_c.frame_timing = l.wdata;
          `LMC_ADDR_DISPLAY_OPT:  next_c.display_opt  = l.wdata;
          `LMC_ADDR_SEG_CURRENT:  next_c.seg_current  = l.wdata;
          `LMC_ADDR_DEVICE_CFG:
          begin
            next_c.device_cfg[7:3] = l.wdata[7:3];
            if (!c.mem_locked)
              next_c.device_cfg[2:0] = l.wdata[2:0];
          end
          `LMC_ADDR_IRQ_MASK:     next_c.irq_mask     = l.wdata;
          `LMC_ADDR_IRQ_FRAME:    next_c.irq_frame    = l.wdata[5:0];
          `LMC_ADDR_POWER_TEST:
          begin
            next_c.power_test = {3'h0, l.wdata[4:0]};
            next_c.test_start = l.wdata[`LMC_PT_MANUAL_TEST];
          end
          `LMC_ADDR_BUS_WDOG:     next_c.bus_wdog     = l.wdata;
          `LMC_ADDR_CLOCK_SRC:    next_c.clock_src    = {4'h0, l.wdata[3:0]};
          default:                next_c.rdata        = c.rdata;
        endcase
      end
      else
      begin
        unique case (l.addr)
          `LMC_ADDR_FRAME_TIMING: next_c.rdata = c.frame_timing;
          `LMC_ADDR_DISPLAY_OPT:  next_c.rdata = c.display_opt;
          `LMC_ADDR_SEG_CURRENT:  next_c.rdata = c.seg_current;
          `LMC_ADDR_DEVICE_CFG:   next_c.rdata = c.device_cfg;
          `LMC_ADDR_IRQ_MASK:     next_c.rdata = c.irq_mask;
          `LMC_ADDR_IRQ_FRAME:    next_c.rdata = {2'h0, c.irq_frame};
          `LMC_ADDR_POWER_TEST:   next_c.rdata = c.power_test;
          `LMC_ADDR_BUS_WDOG:     next_c.rdata = c.bus_wdog;
          `LMC_ADDR_CLOCK_SRC:    next_c.rdata = c.clock_src;
          `LMC_ADDR_IRQ_STATUS:
          begin
            next_c.rdata      = c.irq_status;
            next_c.irq_status = `LMC_CLR_IRQ_STATUS;
          end
          default:                next_c.rdata = 8'h00;
        endcase
      end
    end

    // automatic open/short test on display start
    if (display_start_i && c.power_test[`LMC_PT_AUTO_TEST] && running)
      next_c.test_start = 1'b1;

    // layout lock on first data section write
    if (data_write_i)
      next_c.mem_locked = 1'b1;

    // frame hold timer
    if (running && movie_active_i && (c.frame_timing[3:0] != 4'h0))
    begin
      if (c.frame_cnt >= frame_lim - 32'h1)
      begin
        next_c.frame_cnt  = 32'h0;
        next_c.frame_tick = 1'b1;
      end
      else
        next_c.frame_cnt = c.frame_cnt + 32'h1;
    end
    else
      next_c.frame_cnt = 32'h0;

    // blink phase
    if (running)
    begin
      if (c.blink_cnt >= blink_lim - 32'h1)
      begin
        next_c.blink_cnt   = 32'h0;
        next_c.blink_phase = ~c.blink_phase;
      end
      else
        next_c.blink_cnt = c.blink_cnt + 32'h1;
    end

    // segment scan, fixed time per segment so refresh scales with count
    if (running)
    begin
      if (c.seg_cnt >= SEG_CYC - 32'h1)
      begin
        next_c.seg_cnt    = 32'h0;
        next_c.seg_strobe = 1'b1;
        next_c.seg        = (c.seg >= scan_lim) ? 4'h0 : c.seg + 4'h1;
      end
      else
        next_c.seg_cnt = c.seg_cnt + 32'h1;
    end

    // sync output divider
    if (c.clock_src[`LMC_CK_SYNC_OUT] && !c.clock_src[`LMC_CK_SYNC_IN])
    begin
      if (c.sync_cnt >= sync_half - 16'h1)
      begin
        next_c.sync_cnt = 16'h0;
        next_c.sync_lvl = ~c.sync_lvl;
      end
      else
        next_c.sync_cnt = c.sync_cnt + 16'h1;
    end
    else
    begin
      next_c.sync_cnt = 16'h0;
      next_c.sync_lvl = 1'b0;
    end

    // bus deadlock watchdog
    if (c.bus_wdog[`LMC_WD_ENABLE] && !c.sda_s2)
    begin
      if (c.wd_cnt >= wd_lim - 32'h1)
      begin
        next_c.wd_cnt    = 32'h0;
        next_c.i2c_reset = 1'b1;
      end
      else
        next_c.wd_cnt = c.wd_cnt + 32'h1;
    end
    else
      next_c.wd_cnt = 32'h0;

    // init clear restarts the display state machine timers
    if (!c.power_test[`LMC_PT_INIT])
    begin
      next_c.frame_cnt   = 32'h0;
      next_c.blink_cnt   = 32'h0;
      next_c.blink_phase = 1'b0;
      next_c.seg_cnt     = 32'h0;
      next_c.seg         = 4'h0;
    end

    // low supply flag cleared at end of display, before new events set
    if (display_end_i && c.device_cfg[`LMC_CFG_LOWVDD_CLR])
      next_c.irq_status[`LMC_IS_LOWVDD] = 1'b0;

    // event flags: set wins over any clear in the same cycle
    if (frame_shown_i && final_pass_i && (frame_idx_i == c.irq_frame))
      next_c.irq_status[`LMC_IS_FRAME] = 1'b1;
    if (c.i2c_reset)
      next_c.irq_status[`LMC_IS_WDOG] = 1'b1;
    if (overtemp_i)
      next_c.irq_status[`LMC_IS_OVERTEMP] = 1'b1;
    if (low_vdd_i)
      next_c.irq_status[`LMC_IS_LOWVDD] = 1'b1;
    if (open_err_i)
      next_c.irq_status[`LMC_IS_OPEN] = 1'b1;
    if (short_err_i)
      next_c.irq_status[`LMC_IS_SHORT] = 1'b1;
    if (movie_done_i)
      next_c.irq_status[`LMC_IS_MOVIE] = 1'b1;
  end

  // core domain registers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      c              <= '0;
      c.frame_timing <= `LMC_RST_FRAME_TIMING;
      c.display_opt  <= `LMC_RST_DISPLAY_OPT;
      c.seg_current  <= `LMC_RST_SEG_CURRENT;
      c.device_cfg   <= `LMC_RST_DEVICE_CFG;
      c.irq_mask     <= `LMC_RST_IRQ_MASK;
      c.irq_frame    <= `LMC_RST_IRQ_FRAME;
      c.power_test   <= `LMC_RST_POWER_TEST;
      c.bus_wdog     <= `LMC_RST_BUS_WDOG;
      c.clock_src    <= `LMC_RST_CLOCK_SRC;
      c.irq_status   <= `LMC_RST_IRQ_STATUS;
      c.sda_s1       <= 1'b1;  // idle bus level, no false deadlock count
      c.sda_s2       <= 1'b1;
    end
    else
      c <= next_c;
  end

  // ---------------------------------------------------------------
  // decoded controls to the display engine
  // ---------------------------------------------------------------
  assign irq_event          = |(c.irq_status & c.irq_mask);
  assign frame_tick_o       = c.frame_tick;
  assign frame_once_o       = (c.frame_timing[3:0] == 4'h0);
  assign fade_en_o          = c.frame_timing[`LMC_FT_FADE] && !c.frame_timing[`LMC_FT_BLOCK];
  assign scroll_left_o      = c.frame_timing[`LMC_FT_DIR_LEFT];
  assign scroll_block_o     = c.frame_timing[`LMC_FT_BLOCK];
  assign scroll_en_o        = c.frame_timing[`LMC_FT_SCROLL];
  assign loops_o            = c.display_opt[7:5];
  assign loop_endless_o     = (c.display_opt[7:5] == `LMC_LOOPS_ENDLESS);
  assign blink_phase_o      = c.blink_phase;
  assign seg_sel_o          = c.seg;
  assign seg_strobe_o       = c.seg_strobe && running;
  assign test_seg_limit_o   = scan_lim;
  assign segment_current_o  = running ? c.seg_current : 8'h00;
  assign led_open_disable_o = c.device_cfg[`LMC_CFG_OPEN_DIS];
  assign common_addr_en_o   = c.device_cfg[`LMC_CFG_COMMON_ADDR];
  assign mem_conf_o         = c.device_cfg[2:0];
  assign mem_locked_o       = c.mem_locked;
  assign test_start_o       = c.test_start;
  assign test_all_o         = c.power_test[`LMC_PT_TEST_ALL];
  assign outputs_off_o      = c.power_test[`LMC_PT_SHDN];
  assign fsm_reset_o        = !c.power_test[`LMC_PT_INIT];
  assign i2c_reset_o        = c.i2c_reset;
  assign osc_en_o           = !c.clock_src[`LMC_CK_SYNC_IN];
  assign ext_clk_sel_o      = c.clock_src[`LMC_CK_SYNC_IN];
  assign sync_o             = c.sync_lvl;
  assign sync_oe_o          = c.clock_src[`LMC_CK_SYNC_OUT] && !c.clock_src[`LMC_CK_SYNC_IN];
  assign irq_o              = 1'b0;
  assign irq_oe_o           = c.device_cfg[`LMC_CFG_LOWVDD_PIN] ? low_vdd_i : irq_event;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_stat_read;
    core_rd && (l.addr == `LMC_ADDR_IRQ_STATUS);
  endsequence
  sequence s_quiet;
    !frame_shown_i && !overtemp_i && !low_vdd_i && !open_err_i && !short_err_i
      && !movie_done_i && !c.i2c_reset;
  endsequence
  sequence s_manual_wr;
    core_wr && (l.addr == `LMC_ADDR_POWER_TEST) && l.wdata[`LMC_PT_MANUAL_TEST];
  endsequence

  property p_fade_block;
    scroll_block_o |-> !fade_en_o;
  endproperty
  a_fade_block: assert property (p_fade_block) else $error("fade in block mode");

  property p_read_clear;
    s_stat_read and s_quiet |=> (c.irq_status == 8'h00) && (c.rdata == $past(c.irq_status));
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared");

  property p_lock;
    c.mem_locked && core_wr && (l.addr == `LMC_ADDR_DEVICE_CFG) |=> $stable(mem_conf_o);
  endproperty
  a_lock: assert property (p_lock) else $error("locked layout changed");

  property p_manual_test;
    s_manual_wr |=> test_start_o;
  endproperty
  a_manual_test: assert property (p_manual_test) else $error("manual test missed");

  property p_scan_bound;
    seg_sel_o <= `LMC_SCAN_MAX;
  endproperty
  a_scan_bound: assert property (p_scan_bound) else $error("segment beyond twelve");

  property p_frame_event;
    frame_shown_i && final_pass_i && (frame_idx_i == c.irq_frame) |=> c.irq_status[7];
  endproperty
  a_frame_event: assert property (p_frame_event) else $error("frame event lost");

  property p_wdog_flag;
    i2c_reset_o |=> c.irq_status[`LMC_IS_WDOG] && !i2c_reset_o;
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog flag lost");

  property p_irq_pin;
    !c.device_cfg[`LMC_CFG_LOWVDD_PIN] && |(c.irq_status & c.irq_mask) |-> irq_oe_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq not asserted");

  property p_shdn_stop;
    outputs_off_o ##1 outputs_off_o |-> $stable(c.seg) && !seg_strobe_o;
  endproperty
  a_shdn_stop: assert property (p_shdn_stop) else $error("scan ran in shutdown");

  property p_sync_dir;
    ext_clk_sel_o |-> !sync_oe_o && !osc_en_o;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin driven as input");
endmodule : lmc_ctrl_regs
`default_nettype wire

/* File: tb/lmc_host_model.sv */
// host model that issues register requests on the link port
`timescale 1ns/1ps
`default_nettype none
module lmc_host_model (
  input  wire logic       link_clk_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  // one request held to its taking edge, then wait for busy to fall
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    logic h;
    n = 0;
    @(posedge link_clk_i) #1;
    {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(posedge link_clk_i) #1;
    {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d}; // released lines lose their value
    h = (busy_i === 1'b1);
    do
    begin
      @(posedge link_clk_i) #1;
      n++;
      h = h | (busy_i === 1'b1);
    end
    while (!(h && busy_i === 1'b0) && n < 40);
    q = rdata_i;
  endtask : acc
endmodule : lmc_host_model
`default_nettype wire

/* File: tb/tb_lmc_ctrl_regs.sv */
// self-checking bench of the led matrix control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_lmc_ctrl_regs;
  logic clock_i = 0, reset_n_i = 0, lck = 0, sda = 1, ts_seen = 0, wd_seen = 0, mov = 0;
  logic wr, rd, busy, fade, sl, blk, sen, endl, shd, soe, osc, irq_oe, cae, ts, i2r;
  logic lod, tal, fsr, ecs, mlk, ftk, fon;
  logic [7:0] q, addr, wdata, rdata, cur, n_tick = '0;
  logic [15:0] ev = '0;
  logic [2:0] lps;
  logic [3:0] lim;
  logic [7:0] rv [9] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h20, 8'h3F, 8'h02, 8'hFF, 8'h00};
  logic [7:0] mv [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h1F, 8'hFF, 8'h0E};
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  initial #3 forever #40 lck = ~lck;
  lmc_host_model H (.link_clk_i(lck), .busy_i(busy), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  lmc_ctrl_regs #(.FRAME_STEP_CYC(20), .BLINK_SHORT_CYC(10), .BLINK_LONG_CYC(20),
    .SEG_CYC(8), .WDOG_UNIT_CYC(4)) DUT (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .link_clk_i(lck), .link_wr_i(wr), .link_rd_i(rd), .link_addr_i(addr),
    .link_wdata_i(wdata), .link_rdata_o(rdata), .link_busy_o(busy), .sda_i(sda),
    .movie_active_i(mov), .display_start_i(ev[7]), .display_end_i(ev[5]),
    .frame_shown_i(ev[15]), .frame_idx_i(ev[13:8]), .final_pass_i(ev[14]), .movie_done_i(ev[0]),
    .overtemp_i(ev[4]), .low_vdd_i(ev[3]), .open_err_i(ev[2]), .short_err_i(ev[1]),
    .data_write_i(ev[6]), .frame_tick_o(ftk), .frame_once_o(fon), .fade_en_o(fade),
    .scroll_left_o(sl), .scroll_block_o(blk), .scroll_en_o(sen), .loops_o(lps),
    .loop_endless_o(endl), .blink_phase_o(), .seg_sel_o(), .seg_strobe_o(),
    .test_seg_limit_o(lim), .segment_current_o(cur), .led_open_disable_o(lod),
    .common_addr_en_o(cae), .mem_conf_o(), .mem_locked_o(mlk), .test_start_o(ts),
    .test_all_o(tal), .outputs_off_o(shd), .fsm_reset_o(fsr), .i2c_reset_o(i2r), .osc_en_o(osc),
    .ext_clk_sel_o(ecs), .sync_o(), .sync_oe_o(soe), .irq_o(), .irq_oe_o(irq_oe));
  // sticky capture of core pulses and the hang limit
  always @(posedge clock_i)
  begin
    ts_seen <= ts_seen | (ts === 1'b1);
    wd_seen <= wd_seen | (i2r === 1'b1);
    if (ftk === 1'b1)
      n_tick <= n_tick + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wr8(input logic [7:0] a, input logic [7:0] d);
    H.acc(1'b1, a, d, q);
  endtask : wr8
  task rdc(input logic [7:0] a, input logic [7:0] e);
    H.acc(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask : rdc
  task pulse(input logic [15:0] v);
    @(posedge clock_i) #1 ev = v;
    @(posedge clock_i) #1 ev = '0;
  endtask : pulse
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    repeat (5) @(posedge lck);
    #1 reset_n_i = 1;
    repeat (2) @(posedge lck);
    chk("irq_oe", irq_oe, 1);
    for (int i = 0; i < 9; i++) rdc(8'h03 + i, rv[i]);
    rdc(8'h0E, 8'h20);
    chk("irq_oe", irq_oe, 0);
    $display("reset test done");
    for (int i = 0; i < 9; i++) wr8(8'h03 + i, (i == 8) ? 8'h0E : 8'hFF);
    for (int i = 0; i < 9; i++) rdc(8'h03 + i, mv[i]);
    chk("fade", fade, 0);
    chk("left", sl, 1);
    chk("block", blk, 1);
    chk("scroll", sen, 1);
    chk("endless", endl, 1);
    chk("limit", lim, 4'hB);
    chk("current", cur, 0);
    chk("off", shd, 1);
    chk("sync_oe", soe, 1);
    chk("osc", osc, 1);
    chk("test", ts_seen, 1);
    chk("common", cae, 1);
    chk("open_dis", lod, 1);
    chk("test_all", tal, 1);
    chk("fsm_reset", fsr, 0);
    chk("ext_clk", ecs, 0);
    wr8(8'h04, 8'hC0);
    chk("endless", endl, 0);
    chk("loops", lps, 3'h6);
    wr8(8'h09, 8'h02);
    chk("current", cur, 8'hFF);
    wr8(8'h03, 8'h80);
    chk("fade", fade, 1);
    $display("field test done");
    wr8(8'h06, 8'h01);
    pulse(8'h40);
    chk("locked", mlk, 1);
    wr8(8'h06, 8'h0A);
    rdc(8'h06, 8'h09);
    wr8(8'h07, 8'h1F);
    pulse(8'h1F);
    chk("irq_oe", irq_oe, 1);
    rdc(8'h0E, 8'h1F);
    chk("irq_oe", irq_oe, 0);
    wr8(8'h06, 8'h89);
    pulse(16'h0008);
    pulse(16'h0020);
    rdc(8'h0E, 8'h00);
    pulse(16'h0028);
    rdc(8'h0E, 8'h08);
    wr8(8'h08, 8'h05);
    pulse(16'h8500);
    pulse(16'hC400);
    rdc(8'h0E, 8'h00);
    pulse(16'hC500);
    rdc(8'h0E, 8'h80);
    chk("once", fon, 1);
    wr8(8'h03, 8'h01);
    chk("once", fon, 0);
    @(posedge clock_i) #1 mov = 1;
    repeat (90) @(posedge clock_i);
    #1 mov = 0;
    chk("ticks", n_tick, 4);
    $display("event test done");
    wr8(8'h0A, 8'h01);
    @(posedge clock_i) #1 sda = 0;
    repeat (30) @(posedge clock_i);
    #1 sda = 1;
    chk("wdog", wd_seen, 1);
    rdc(8'h0E, 8'h40);
    $display("watchdog test done");
    final_report();
  end
endmodule : tb_lmc_ctrl_regs
`default_nettype wire
